// ===== rtl/dsp_operand_field_decoder.sv
// Operand field decoder: addressing modes, X/Y prefetch, multiplier
// operands, accumulator write-back and the add forms, with a Wishbone
// classic slave for instruction load, operands and decoded readback.
// Assumes a fetch stage and the Wishbone master on the same clock.
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dsp_operand_field_decoder (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Fetch stage
    input  wire logic [23:0] instr_i,
    input  wire logic        instr_valid_i,
    // Addressing modes
    output logic             decode_valid_o,
    output logic      [2:0]  src_mode_o,
    output logic      [2:0]  dest_mode_o,
    // X prefetch
    output logic             x_fetch_en_o,
    output logic      [3:0]  x_ptr_reg_o,
    output logic             x_add_ofs_o,
    output logic      [3:0]  x_adjust_o,
    output logic      [3:0]  x_dest_reg_o,
    // Y prefetch
    output logic             y_fetch_en_o,
    output logic      [3:0]  y_ptr_reg_o,
    output logic             y_add_ofs_o,
    output logic      [3:0]  y_adjust_o,
    output logic      [3:0]  y_dest_reg_o,
    // Multiplier and write-back
    output logic      [3:0]  square_reg_o,
    output logic      [3:0]  mul_reg_a_o,
    output logic      [3:0]  mul_reg_b_o,
    output logic             mul_invalid_o,
    output logic      [1:0]  wb_mode_o,
    output logic      [3:0]  wb_ptr_reg_o,
    output logic      [3:0]  wb_adjust_o,
    output logic             wb_invalid_o,
    // Add result
    output logic      [15:0] add_result_o,
    output logic      [4:0]  add_flags_o,
    output logic             add_to_file_o,
    output logic             add_done_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [23:0]                    instr;
        logic [15:0]                    opa;
        logic [15:0]                    opb;
        logic                           load_pend;
        logic                           valid;
        logic                           add_done;
        logic [15:0]                    result;
        logic [4:0]                     flags;
        logic                           to_file;
        logic                           ack;
        logic [31:0]                    rdata;
        operand_decode_pkg::addr_mode_e src_mode;
        operand_decode_pkg::addr_mode_e dest_mode;
        operand_decode_pkg::prefetch_s  xpf;
        operand_decode_pkg::prefetch_s  ypf;
        logic [3:0]                     x_dest;
        logic [3:0]                     y_dest;
        logic [3:0]                     square_reg;
        logic [3:0]                     mul_a;
        logic [3:0]                     mul_b;
        logic                           mul_invalid;
        operand_decode_pkg::wb_mode_e   wb;
    } state_s;

    state_s s;
    state_s next_s;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic operand_decode_pkg::addr_mode_e decode_mode(
        input logic [2:0] code
    );
        operand_decode_pkg::addr_mode_e m;
        if (code[2:1] == 2'h3) begin
            m = operand_decode_pkg::MODE_OFFSET;
        end else begin
            m = operand_decode_pkg::addr_mode_e'(code);
        end
        return m;
    endfunction

    function automatic operand_decode_pkg::prefetch_s decode_prefetch(
        input logic [3:0] op,
        input logic [3:0] lo_reg,
        input logic [3:0] hi_reg
    );
        operand_decode_pkg::prefetch_s r;
        r.en      = 1'b1;
        r.ptr_reg = op[3] ? hi_reg : lo_reg;
        r.add_ofs = 1'b0;
        r.adjust  = operand_decode_pkg::ADJ_NONE;
        case (op[2:0])
            3'h1: r.adjust = operand_decode_pkg::ADJ_P2;
            3'h2: r.adjust = operand_decode_pkg::ADJ_P4;
            3'h3: r.adjust = operand_decode_pkg::ADJ_P6;
            3'h4: begin
                if (op[3]) begin
                    r.add_ofs = 1'b1;
                end else begin
                    // No read, pointers left alone
                    r.en = 1'b0;
                end
            end
            3'h5: r.adjust = operand_decode_pkg::ADJ_M6;
            3'h6: r.adjust = operand_decode_pkg::ADJ_M4;
            3'h7: r.adjust = operand_decode_pkg::ADJ_M2;
            default: r.adjust = operand_decode_pkg::ADJ_NONE;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] reg_4_to_7(input logic [1:0] code);
        return 4'(operand_decode_pkg::DEST_BASE + {2'h0, code});
    endfunction

    function automatic logic [31:0] apply_sel(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < operand_decode_pkg::SEL_W; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Add operand selection
    // ------------------------------------------------------------------
    logic [15:0] add_a;
    logic [15:0] add_b;
    logic        add_form;
    logic        add_byte;
    logic [15:0] add_sum;
    logic [4:0]  add_flags;
    logic        add_file_dest;

    always_comb begin
        add_a         = s.opa;
        add_b         = s.opb;
        add_form      = 1'b0;
        add_file_dest = 1'b0;
        add_byte      = s.instr[operand_decode_pkg::BYTE_BIT];
        if (s.instr[operand_decode_pkg::INSTR_W-1:operand_decode_pkg::OP9_LSB]
            == operand_decode_pkg::OP_ADD_FILE) begin
            // File value plus default register
            add_form      = 1'b1;
            add_file_dest = s.instr[operand_decode_pkg::DEST_BIT];
        end else if (s.instr[operand_decode_pkg::INSTR_W-1:
                             operand_decode_pkg::OP9_LSB]
                     == operand_decode_pkg::OP_ADD_LIT) begin
            add_form = 1'b1;
            add_a    = 16'(s.instr[operand_decode_pkg::LIT10_LSB +:
                                   operand_decode_pkg::LIT10_W]);
        end else if (s.instr[operand_decode_pkg::INSTR_W-1:
                             operand_decode_pkg::OP5_LSB]
                     == operand_decode_pkg::OP_ADD_WB) begin
            add_form = 1'b1;
            if (s.instr[operand_decode_pkg::LIT5_TAG_LSB +: 2]
                == operand_decode_pkg::LIT5_TAG) begin
                add_b = 16'(s.instr[operand_decode_pkg::LIT5_W-1:0]);
            end
        end
    end

    add_flag_unit u_add (
        .a_i     (add_a),
        .b_i     (add_b),
        .byte_i  (add_byte),
        .sum_o   (add_sum),
        .flags_o (add_flags)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic bus_req;
    logic bus_wr;

    always_comb begin
        next_s    = s;
        bus_req   = wb_cyc_i && wb_stb_i;
        // Write lands on the edge that samples ack high
        bus_wr    = bus_req && wb_we_i && s.ack;

        // Bus answer: registered ack, one cycle low between requests
        next_s.ack   = bus_req && !s.ack;
        next_s.rdata = '0;
        if (bus_req && !s.ack) begin
            unique case (wb_adr_i)
                operand_decode_pkg::REG_INSTR:
                    next_s.rdata = 32'(s.instr);
                operand_decode_pkg::REG_OPA:
                    next_s.rdata = 32'(s.opa);
                operand_decode_pkg::REG_OPB:
                    next_s.rdata = 32'(s.opb);
                operand_decode_pkg::REG_RESULT:
                    next_s.rdata = 32'(s.result);
                operand_decode_pkg::REG_STATUS:
                    next_s.rdata = 32'({s.valid, 2'h0, s.to_file,
                                        3'h0, s.flags});
                operand_decode_pkg::REG_ADDRDEC:
                    next_s.rdata = 32'({s.dest_mode, 1'b0, s.src_mode});
                operand_decode_pkg::REG_PREFETCH:
                    next_s.rdata = 32'({s.y_dest, s.ypf, 2'h0,
                                        s.x_dest, s.xpf});
                operand_decode_pkg::REG_MACDEC:
                    next_s.rdata = 32'({s.wb, 2'h0, s.mul_invalid,
                                        s.mul_b, s.mul_a, s.square_reg});
                default: next_s.rdata = '0;
            endcase
        end

        // Operand registers
        if (bus_wr && wb_adr_i == operand_decode_pkg::REG_OPA) begin
            next_s.opa = 16'(apply_sel(32'(s.opa), wb_dat_i, wb_sel_i));
        end
        if (bus_wr && wb_adr_i == operand_decode_pkg::REG_OPB) begin
            next_s.opb = 16'(apply_sel(32'(s.opb), wb_dat_i, wb_sel_i));
        end

        // Instruction load; fetch port has priority over the bus
        next_s.load_pend = 1'b0;
        if (instr_valid_i) begin
            next_s.instr     = instr_i;
            next_s.load_pend = 1'b1;
        end else if (bus_wr && wb_adr_i == operand_decode_pkg::REG_INSTR) begin
            next_s.instr     = 24'(apply_sel(32'(s.instr), wb_dat_i, wb_sel_i));
            next_s.load_pend = 1'b1;
        end

        // Field decode, one cycle behind the instruction register
        next_s.src_mode  = decode_mode(
            s.instr[operand_decode_pkg::SRC_MODE_LSB +:
                    operand_decode_pkg::MODE_W]);
        next_s.dest_mode = decode_mode(
            s.instr[operand_decode_pkg::DEST_MODE_LSB +:
                    operand_decode_pkg::MODE_W]);
        next_s.xpf = decode_prefetch(
            s.instr[operand_decode_pkg::X_OP_LSB +: operand_decode_pkg::PF_W],
            operand_decode_pkg::X_PTR_LO, operand_decode_pkg::X_PTR_HI);
        next_s.ypf = decode_prefetch(
            s.instr[operand_decode_pkg::Y_OP_LSB +: operand_decode_pkg::PF_W],
            operand_decode_pkg::Y_PTR_LO, operand_decode_pkg::Y_PTR_HI);
        next_s.x_dest = reg_4_to_7(
            s.instr[operand_decode_pkg::X_DEST_LSB +: 2]);
        next_s.y_dest = reg_4_to_7(
            s.instr[operand_decode_pkg::Y_DEST_LSB +: 2]);
        next_s.square_reg = reg_4_to_7(
            s.instr[operand_decode_pkg::MUL_SQ_LSB +: 2]);

        next_s.mul_invalid = 1'b0;
        next_s.mul_a       = 4'h0;
        next_s.mul_b       = 4'h0;
        case (s.instr[operand_decode_pkg::MUL_PAIR_LSB +: 3])
            3'h0: {next_s.mul_a, next_s.mul_b} = 8'h45;
            3'h1: {next_s.mul_a, next_s.mul_b} = 8'h46;
            3'h2: {next_s.mul_a, next_s.mul_b} = 8'h47;
            3'h4: {next_s.mul_a, next_s.mul_b} = 8'h56;
            3'h5: {next_s.mul_a, next_s.mul_b} = 8'h57;
            3'h6: {next_s.mul_a, next_s.mul_b} = 8'h67;
            default: next_s.mul_invalid = 1'b1;
        endcase

        next_s.wb = operand_decode_pkg::wb_mode_e'(
            s.instr[operand_decode_pkg::WB_LSB +: 2]);

        // Add executes once, in the cycle after the load
        next_s.add_done = 1'b0;
        if (s.load_pend) begin
            next_s.valid = 1'b1;
            if (add_form) begin
                next_s.result   = add_sum;
                next_s.flags    = add_flags;
                next_s.to_file  = add_file_dest;
                next_s.add_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o       = s.rdata;
    assign wb_ack_o       = s.ack;
    assign decode_valid_o = s.valid;
    assign src_mode_o     = s.src_mode;
    assign dest_mode_o    = s.dest_mode;
    assign x_fetch_en_o   = s.xpf.en;
    assign x_ptr_reg_o    = s.xpf.ptr_reg;
    assign x_add_ofs_o    = s.xpf.add_ofs;
    assign x_adjust_o     = s.xpf.adjust;
    assign x_dest_reg_o   = s.x_dest;
    assign y_fetch_en_o   = s.ypf.en;
    assign y_ptr_reg_o    = s.ypf.ptr_reg;
    assign y_add_ofs_o    = s.ypf.add_ofs;
    assign y_adjust_o     = s.ypf.adjust;
    assign y_dest_reg_o   = s.y_dest;
    assign square_reg_o   = s.square_reg;
    assign mul_reg_a_o    = s.mul_a;
    assign mul_reg_b_o    = s.mul_b;
    assign mul_invalid_o  = s.mul_invalid;
    assign wb_mode_o      = s.wb;
    // Write-back goes through register 13, stepped by 2 when indirect
    assign wb_ptr_reg_o   = operand_decode_pkg::WB_REG;
    assign wb_adjust_o    = (s.wb == operand_decode_pkg::WB_POSTINC)
                          ? 4'(operand_decode_pkg::ADJ_P2)
                          : 4'(operand_decode_pkg::ADJ_NONE);
    assign wb_invalid_o   = (s.wb == operand_decode_pkg::WB_INVALID);
    assign add_result_o   = s.result;
    assign add_flags_o    = s.flags;
    assign add_to_file_o  = s.to_file;
    assign add_done_o     = s.add_done;

endmodule // dsp_operand_field_decoder

`default_nettype wire

// ===== rtl/operand_decode_pkg.sv
// Constants, field layout and types for the operand field decoder.
// Assumes a 24-bit instruction word and a 16-bit datapath.
package operand_decode_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int INSTR_W = 24;
    localparam int DATA_W  = 16;
    localparam int BUS_W   = 32;
    localparam int ADR_W   = 8;
    localparam int SEL_W   = 4;
    localparam int REG_W   = 4;
    localparam int FLAG_W  = 5;
    localparam int MODE_W  = 3;
    localparam int PF_W    = 4;

    // ------------------------------------------------------------------
    // Instruction field positions
    // ------------------------------------------------------------------
    localparam int SRC_MODE_LSB  = 4;
    localparam int DEST_MODE_LSB = 11;
    localparam int MUL_PAIR_LSB  = 16;
    localparam int MUL_SQ_LSB    = 16;
    localparam int X_DEST_LSB    = 12;
    localparam int Y_DEST_LSB    = 10;
    localparam int X_OP_LSB      = 6;
    localparam int Y_OP_LSB      = 2;
    localparam int WB_LSB        = 0;
    localparam int OP9_LSB       = 15;
    localparam int OP5_LSB       = 19;
    localparam int BYTE_BIT      = 14;
    localparam int DEST_BIT      = 13;
    localparam int LIT10_LSB     = 4;
    localparam int LIT10_W       = 10;
    localparam int LIT5_W        = 5;
    localparam int LIT5_TAG_LSB  = 5;

    // Add opcodes
    localparam logic [8:0] OP_ADD_FILE = 9'h168;
    localparam logic [8:0] OP_ADD_LIT  = 9'h160;
    localparam logic [4:0] OP_ADD_WB   = 5'h08;
    localparam logic [1:0] LIT5_TAG    = 2'h3;

    // ------------------------------------------------------------------
    // Working register numbers
    // ------------------------------------------------------------------
    localparam logic [3:0] X_PTR_LO  = 4'h8;
    localparam logic [3:0] X_PTR_HI  = 4'h9;
    localparam logic [3:0] Y_PTR_LO  = 4'hA;
    localparam logic [3:0] Y_PTR_HI  = 4'hB;
    localparam logic [3:0] OFS_REG   = 4'hC;
    localparam logic [3:0] WB_REG    = 4'hD;
    localparam logic [3:0] DEST_BASE = 4'h4;

    // Pointer adjustments
    localparam logic signed [3:0] ADJ_NONE = 4'sh0;
    localparam logic signed [3:0] ADJ_P2   = 4'sh2;
    localparam logic signed [3:0] ADJ_P4   = 4'sh4;
    localparam logic signed [3:0] ADJ_P6   = 4'sh6;
    localparam logic signed [3:0] ADJ_M6   = -4'sh6;
    localparam logic signed [3:0] ADJ_M4   = -4'sh4;
    localparam logic signed [3:0] ADJ_M2   = -4'sh2;

    // ------------------------------------------------------------------
    // Adder flag layout
    // ------------------------------------------------------------------
    localparam int FLG_C  = 0;
    localparam int FLG_Z  = 1;
    localparam int FLG_OV = 2;
    localparam int FLG_N  = 3;
    localparam int FLG_DC = 4;
    localparam int NIB_W    = 4;
    localparam int BYTE_W   = 8;
    localparam int BYTE_MSB = 7;
    localparam int WORD_MSB = 15;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_INSTR    = 8'h00;
    localparam logic [7:0] REG_OPA      = 8'h04;
    localparam logic [7:0] REG_OPB      = 8'h08;
    localparam logic [7:0] REG_RESULT   = 8'h0C;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_ADDRDEC  = 8'h14;
    localparam logic [7:0] REG_PREFETCH = 8'h18;
    localparam logic [7:0] REG_MACDEC   = 8'h1C;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_DIRECT  = 3'h0,
        MODE_IND     = 3'h1,
        MODE_POSTDEC = 3'h2,
        MODE_POSTINC = 3'h3,
        MODE_PREDEC  = 3'h4,
        MODE_PREINC  = 3'h5,
        MODE_OFFSET  = 3'h6
    } addr_mode_e;

    typedef enum logic [1:0] {
        WB_DIRECT  = 2'h0,
        WB_POSTINC = 2'h1,
        WB_NONE    = 2'h2,
        WB_INVALID = 2'h3
    } wb_mode_e;

    typedef struct packed {
        logic              en;
        logic [3:0]        ptr_reg;
        logic              add_ofs;
        logic signed [3:0] adjust;
    } prefetch_s;

endpackage : operand_decode_pkg

// ===== rtl/add_flag_unit.sv
// Adder for the add forms: sum and status flags in byte or word width.
// Purely combinational; the caller registers sum and flags.
`timescale 1ns/1ps
`default_nettype none

module add_flag_unit (
    // Operands
    input  wire logic [15:0] a_i,
    input  wire logic [15:0] b_i,
    input  wire logic        byte_i,
    // Result
    output logic      [15:0] sum_o,
    output logic      [4:0]  flags_o
);

    logic [16:0] full;
    logic [8:0]  low;
    logic [4:0]  nib;

    always_comb begin
        full = {1'b0, a_i} + {1'b0, b_i};
        low  = {1'b0, a_i[operand_decode_pkg::BYTE_MSB:0]}
             + {1'b0, b_i[operand_decode_pkg::BYTE_MSB:0]};
        nib  = {1'b0, a_i[operand_decode_pkg::NIB_W-1:0]}
             + {1'b0, b_i[operand_decode_pkg::NIB_W-1:0]};
        flags_o = '0;
        if (byte_i) begin
            // Upper byte reads as zero in byte width
            sum_o = {8'h00, low[operand_decode_pkg::BYTE_MSB:0]};
            flags_o[operand_decode_pkg::FLG_DC] = nib[operand_decode_pkg::NIB_W];
            flags_o[operand_decode_pkg::FLG_C]  =
                low[operand_decode_pkg::BYTE_W];
            flags_o[operand_decode_pkg::FLG_N]  =
                low[operand_decode_pkg::BYTE_MSB];
            flags_o[operand_decode_pkg::FLG_OV] =
                (a_i[operand_decode_pkg::BYTE_MSB]
                 == b_i[operand_decode_pkg::BYTE_MSB])
                && (low[operand_decode_pkg::BYTE_MSB]
                 != a_i[operand_decode_pkg::BYTE_MSB]);
            flags_o[operand_decode_pkg::FLG_Z]  =
                (low[operand_decode_pkg::BYTE_MSB:0] == 8'h00);
        end else begin
            sum_o = full[operand_decode_pkg::WORD_MSB:0];
            // Digit carry is the carry out of the low byte in word width
            flags_o[operand_decode_pkg::FLG_DC] = low[operand_decode_pkg::BYTE_W];
            flags_o[operand_decode_pkg::FLG_C]  =
                full[operand_decode_pkg::DATA_W];
            flags_o[operand_decode_pkg::FLG_N]  =
                full[operand_decode_pkg::WORD_MSB];
            flags_o[operand_decode_pkg::FLG_OV] =
                (a_i[operand_decode_pkg::WORD_MSB]
                 == b_i[operand_decode_pkg::WORD_MSB])
                && (full[operand_decode_pkg::WORD_MSB]
                 != a_i[operand_decode_pkg::WORD_MSB]);
            flags_o[operand_decode_pkg::FLG_Z]  =
                (full[operand_decode_pkg::WORD_MSB:0] == 16'h0000);
        end
    end

endmodule // add_flag_unit

`default_nettype wire

// ===== sim/fetch_stage_model.sv
// Fetch stage stand-in: issues one instruction word per request.
// Assumes requests are set just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fetch_stage_model (
    input  wire logic        clock_i,
    input  wire logic        req_i,
    input  wire logic [23:0] word_i,
    output logic      [23:0] instr_o,
    output logic             valid_o
);
    initial {valid_o, instr_o} = '0;
    // Idle word is inverted so a stale copy never passes for a fetch
    always @(posedge clock_i) begin
        valid_o <= req_i;
        instr_o <= req_i ? word_i : ~instr_o;
    end
endmodule // fetch_stage_model
`default_nettype wire

// ===== sim/dsp_operand_field_decoder_properties.sv
// Checker: decoded fields against the instruction loaded two edges back.
// Assumes loads come only from the fetch strobe.
`timescale 1ns/1ps
`default_nettype none
module decoder_props (
    input wire logic        clock_i, sys_rst_i, instr_valid_i,
    input wire logic        x_fetch_en_o, y_fetch_en_o, mul_invalid_o,
    input wire logic        wb_invalid_o, add_done_o,
    input wire logic [23:0] instr_i,
    input wire logic [2:0]  src_mode_o,
    input wire logic [3:0]  x_ptr_reg_o, x_adjust_o, y_ptr_reg_o,
    input wire logic [3:0]  y_adjust_o, square_reg_o, wb_adjust_o,
    input wire logic [1:0]  wb_mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Load edge, pending cycle, then decoded outputs
    sequence ld_s(ok);
        instr_valid_i && ok ##2 1'b1;
    endsequence
    src_off_a:
    assert property (ld_s(&instr_i[6:5]) |-> src_mode_o == 3'h6) else
        $error("src offset mode");
    x_ptr_a:
    assert property (ld_s(instr_i[9:6] != 4'h4) |-> x_fetch_en_o &&
        x_ptr_reg_o == {3'h4, $past(instr_i[9], 2)}) else $error("x ptr");
    x_skip_a:
    assert property (ld_s(instr_i[9:6] == 4'h4) |-> !x_fetch_en_o &&
        x_adjust_o == 4'h0) else $error("x skip");
    y_ptr_a:
    assert property (ld_s(instr_i[5:2] != 4'h4) |-> y_fetch_en_o &&
        y_ptr_reg_o == {3'h5, $past(instr_i[5], 2)}) else $error("y ptr");
    y_skip_a:
    assert property (ld_s(instr_i[5:2] == 4'h4) |-> !y_fetch_en_o &&
        y_adjust_o == 4'h0) else $error("y skip");
    square_a:
    assert property (ld_s(1'b1) |-> square_reg_o ==
        {2'h1, $past(instr_i[17:16], 2)}) else $error("square reg");
    pair_bad_a:
    assert property (ld_s(&instr_i[17:16]) |-> mul_invalid_o) else
        $error("pair invalid");
    wb_sel_a:
    assert property (wb_invalid_o == (wb_mode_o == 2'h3) && wb_adjust_o
        == ((wb_mode_o == 2'h1) ? 4'h2 : 4'h0)) else $error("writeback");
    wb_code_a:
    assert property (ld_s(1'b1) |-> wb_mode_o == $past(instr_i[1:0], 2))
        else $error("wb code");
    add_done_a:
    assert property (ld_s(instr_i[23:15] == 9'h168) |-> add_done_o ##1
        !add_done_o) else $error("add done");
endmodule // decoder_props
bind dsp_operand_field_decoder decoder_props chk_u (.clock_i, .sys_rst_i,
    .instr_valid_i, .x_fetch_en_o, .y_fetch_en_o, .mul_invalid_o,
    .wb_invalid_o, .instr_i, .src_mode_o, .x_ptr_reg_o, .x_adjust_o,
    .y_ptr_reg_o, .y_adjust_o, .square_reg_o, .wb_adjust_o, .wb_mode_o,
    .add_done_o);
`default_nettype wire

// ===== sim/dsp_operand_field_decoder_tb_top.sv
// Bench: field tables and add forms, read back over Wishbone.
// Assumes the fetch model feeds the decoder's instruction port.
`timescale 1ns/1ps
`default_nettype none
module dsp_operand_field_decoder_tb_top;
    logic clock_i = 0, sys_rst_i = 1, cyc = 0, we = 0, req = 0, vld, ack, tf;
    logic [7:0]  adr = '0;
    logic [31:0] wd = '0, rdat, rd;
    logic [23:0] word = '0, ins;
    logic [15:0] res;
    logic [4:0]  flg;
    int fails = 0, checks_done = 0;
    always #50 clock_i = ~clock_i;
    fetch_stage_model fm_u (.clock_i, .req_i(req), .word_i(word),
        .instr_o(ins), .valid_o(vld));
    dsp_operand_field_decoder dut_u (.clock_i, .sys_rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .instr_i(ins),
        .instr_valid_i(vld), .decode_valid_o(), .src_mode_o(),
        .dest_mode_o(), .x_fetch_en_o(), .x_ptr_reg_o(), .x_add_ofs_o(),
        .x_adjust_o(), .x_dest_reg_o(), .y_fetch_en_o(), .y_ptr_reg_o(),
        .y_add_ofs_o(), .y_adjust_o(), .y_dest_reg_o(), .square_reg_o(),
        .mul_reg_a_o(), .mul_reg_b_o(), .mul_invalid_o(), .wb_mode_o(),
        .wb_ptr_reg_o(), .wb_adjust_o(), .wb_invalid_o(),
        .add_result_o(res), .add_flags_o(flg), .add_to_file_o(tf),
        .add_done_o());
    task automatic chk(input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input [31:0] d);
        @(posedge clock_i);
        {cyc, we, adr, wd} <= {1'b1, w, a, d};
        do @(posedge clock_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 0;
    endtask
    task automatic ld(input logic [23:0] w);
        @(posedge clock_i);
        {req, word} <= {1'b1, w};
        @(posedge clock_i);
        req <= 0;
        repeat (4) @(posedge clock_i);
    endtask
    function automatic logic [2:0] md(input logic [2:0] m);
        return (m[2:1] == 2'h3) ? 3'h6 : m;
    endfunction
    // Step is the op code doubled, read as two's complement, except 0 for codes 4 and 12
    function automatic logic [13:0] pf(input logic [3:0] op, lo,
                                       input logic [1:0] t);
        return {2'h1, t, op != 4'h4, lo | op[3], op == 4'hC,
                (op[2:0] == 3'h4) ? 4'h0 : {op[2:0], 1'b0}};
    endfunction
    task automatic t_fields;
        logic [23:0] w;
        logic [7:0] p;
        for (int c = 0; c < 16; c++) begin
            w = {6{c[3:0]}};
            p = 64'h0076_7565_0074_6454 >> (w[18:16] * 8);
            ld(w);
            bus(0, 8'h14, 0);
            chk(rd, {md(w[13:11]), 1'b0, md(w[6:4])});
            bus(0, 8'h18, 0);
            chk(rd, {2'h0, pf(w[5:2], 4'hA, w[11:10]),
                2'h0, pf(w[9:6], 4'h8, w[13:12])});
            bus(0, 8'h1C, 0);
            chk(rd, {w[1:0], 2'h0, p == 0, p,
                2'h1, w[17:16]});
        end
    endtask
    task automatic t_add;
        bus(1, 8'h04, 32'h0000_7FFF);
        bus(1, 8'h08, 32'h0000_0001);
        ld({9'h168, 15'h0000});
        chk({tf, flg, res}, {1'b0, 5'h1C, 16'h8000});
        bus(1, 8'h0C, 32'h0000_1234);
        bus(0, 8'h0C, 0);
        chk(rd, 32'h0000_8000);
        ld({9'h168, 2'h3, 13'h0000});
        chk({tf, flg, res}, {1'b1, 5'h13, 16'h0000});
        bus(0, 8'h10, 0);
        chk(rd, 32'h0000_0913);
        ld({9'h160, 1'b0, 10'h001, 4'h0});
        chk({tf, flg, res}, {1'b0, 5'h00, 16'h0002});
        ld({5'h08, 12'h000, 2'h3, 5'h01});
        chk({tf, flg, res}, {1'b0, 5'h1C, 16'h8000});
        bus(1, 8'hFC, 32'h0000_FFFF);
        bus(0, 8'hFC, 0);
        chk(rd, 32'h0000_0000);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 0;
        t_fields;
        t_add;
        close_out;
    end
    initial begin
        #500_000;
        fails++;
        close_out;
    end
endmodule // dsp_operand_field_decoder_tb_top
`default_nettype wire
